// ### common/ppedp_regs.svh
// Register offsets, field positions, reset values for the printer port pins.
`ifndef PPEDP_REGS_SVH
`define PPEDP_REGS_SVH
`define PPEDP_OFF_PMC      6'h00
`define PPEDP_OFF_PCFG     6'h04
`define PPEDP_OFF_FCTL     6'h08
`define PPEDP_OFF_PCTL     6'h0c
`define PPEDP_OFF_STAT     6'h10
`define PPEDP_OFF_DATA     6'h14
`define PPEDP_PMC_DMA_BIT  3
`define PPEDP_PCFG_ECP_BIT 2
`define PPEDP_FCTL_PNF_BIT 2
`define PPEDP_PCTL_SEL_BIT 3
`define PPEDP_PCTL_DIR_BIT 4
`define PPEDP_PCTL_MODE_LO 5
`define PPEDP_MODE_ECP     3'h3
`define PPEDP_RST_BYTE     8'h00
`define PPEDP_RESP_OKAY    2'h0
`define PPEDP_RESP_SLVERR  2'h2
`endif

// ### common/ppedp_pkg.sv
// Types shared by the printer port pin logic.
`default_nettype none
package ppedp_pkg;
    typedef logic [7:0] ppedp_byte_t;
    typedef logic [2:0] ppedp_mode_t;
endpackage : ppedp_pkg
`default_nettype wire

// ### hw/ppedp_top.sv
// Printer port pin control: ECP DMA handshake, status pins, select, data.
`timescale 1ns/10ps
`default_nettype none
`include "ppedp_regs.svh"

module ppedp_top
(
    // Clock and reset.
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // AXI4-Lite write address and data.
    input  wire logic               s_axi_awvalid,
    output var  logic               s_axi_awready,
    input  wire logic [5:0]         s_axi_awaddr,
    input  wire logic               s_axi_wvalid,
    output var  logic               s_axi_wready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    // AXI4-Lite write response.
    output var  logic               s_axi_bvalid,
    input  wire logic               s_axi_bready,
    output var  logic [1:0]         s_axi_bresp,
    // AXI4-Lite read.
    input  wire logic               s_axi_arvalid,
    output var  logic               s_axi_arready,
    input  wire logic [5:0]         s_axi_araddr,
    output var  logic               s_axi_rvalid,
    input  wire logic               s_axi_rready,
    output var  logic [31:0]        s_axi_rdata,
    output var  logic [1:0]         s_axi_rresp,
    // Host DMA controller side.
    input  wire logic               printer_dma_ack_n,
    input  wire logic               dma_rd_n,
    input  wire logic               dma_wr_n,
    input  wire ppedp_pkg::ppedp_byte_t dma_wdata,
    output var  ppedp_pkg::ppedp_byte_t dma_rdata,
    output var  logic               printer_dma_request,
    output var  logic               printer_dma_request_oe_n,
    // Printer status and select pins.
    input  wire logic               paper_out,
    input  wire logic               printer_selected,
    input  wire logic               printer_select_n_i,
    output var  logic               printer_select_n_o,
    output var  logic               printer_select_n_oe_n,
    // Printer-or-floppy strap pin and its decoded meanings.
    input  wire logic               printer_or_floppy_select,
    output var  logic               shared_port_mode,
    output var  logic               drive_two_present,
    output var  logic               ident_in,
    // Port data lines and their transfer handshake.
    input  wire ppedp_pkg::ppedp_byte_t port_data_lines_i,
    output var  ppedp_pkg::ppedp_byte_t port_data_lines_o,
    output var  logic               port_data_lines_oe_n,
    output var  logic               port_data_valid,
    input  wire logic               port_data_ready
);
    import ppedp_pkg::*;

    // Control registers.
    ppedp_byte_t power_mode_control_reg;
    ppedp_byte_t port_config_ctrl_reg;
    ppedp_byte_t function_control_reg;
    ppedp_byte_t port_ctrl_reg;
    // AXI state.
    logic        aw_held_reg;
    logic [5:0]  aw_addr_reg;
    logic        w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    // Decoded configuration.
    logic        dma_cfg;
    logic        ecp_en;
    logic        ecp_mode;
    logic        ack_active;
    logic        dir_in;
    // Synchronisers and strobe history.
    logic [1:0]  paper_sync_reg;
    logic [1:0]  select_sync_reg;
    logic        wr_n_prev_reg;
    logic        rd_n_prev_reg;
    // Two-entry data buffer.
    ppedp_byte_t buf_mem [0:1];
    logic        buf_wptr_reg;
    logic        buf_rptr_reg;
    logic [1:0]  buf_count_reg;
    logic        buf_in_valid;
    logic        buf_in_ready;
    ppedp_byte_t buf_in_data;
    logic        buf_out_valid;
    logic        buf_pop;
    // Write handling.
    logic        wr_go;
    logic        wr_is_data;
    logic        wr_bad;
    logic        dma_push;
    logic        sw_push;
    logic        dma_read;
    logic        dma_request_reg;

    // Configuration bits decoded from the control registers.
    assign dma_cfg  = power_mode_control_reg[`PPEDP_PMC_DMA_BIT];
    assign ecp_en   = port_config_ctrl_reg[`PPEDP_PCFG_ECP_BIT];
    assign ecp_mode = port_ctrl_reg[`PPEDP_PCTL_MODE_LO +: 3]
                      == `PPEDP_MODE_ECP;
    assign dir_in   = port_ctrl_reg[`PPEDP_PCTL_DIR_BIT];

    // Shared pin steering for acknowledge and identification.
    assign ack_active = dma_cfg & ecp_mode
                        & ~printer_dma_ack_n;
    assign ident_in   = dma_cfg ? 1'b1 : printer_dma_ack_n;

    // Printer-or-floppy pin decode.
    assign shared_port_mode  = function_control_reg[`PPEDP_FCTL_PNF_BIT]
                               ? printer_or_floppy_select : 1'b1;
    assign drive_two_present = function_control_reg[`PPEDP_FCTL_PNF_BIT]
                               ? 1'b0 : printer_or_floppy_select;

    // Select line is driven low when the control bit is one, else released.
    assign printer_select_n_o    = 1'b0;
    assign printer_select_n_oe_n =
        ~port_ctrl_reg[`PPEDP_PCTL_SEL_BIT];

    // Request pin floats unless ECP is enabled and DMA is configured.
    assign printer_dma_request_oe_n = ~(ecp_en & dma_cfg);

    // Two-stage synchronisers for the printer status inputs.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            paper_sync_reg  <= 2'h0;
            select_sync_reg <= 2'h0;
        end
        else
        begin
            paper_sync_reg  <= {paper_sync_reg[0], paper_out};
            select_sync_reg <= {select_sync_reg[0],
                                printer_selected};
        end
    end

    // Strobe history for falling edge detection.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_n_prev_reg <= 1'b1;
            rd_n_prev_reg <= 1'b1;
        end
        else
        begin
            wr_n_prev_reg <= dma_wr_n;
            rd_n_prev_reg <= dma_rd_n;
        end
    end

    // Strobes count as DMA transfers only under an active acknowledge.
    assign dma_push = ack_active & ~dir_in & wr_n_prev_reg
                      & ~dma_wr_n;
    assign dma_read = ack_active & dir_in & rd_n_prev_reg
                      & ~dma_rd_n;

    // Byte captured from the data lines for a DMA read.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            dma_rdata <= `PPEDP_RST_BYTE;
        else if (dma_read)
            dma_rdata <= port_data_lines_i;
    end

    // The request asks for a byte while the buffer has room, or at any time in reverse direction; ECP mode only.
    // It drops in the same cycle as the pin is released by the configuration.
    assign printer_dma_request = dma_request_reg & ecp_en & dma_cfg & ecp_mode;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            dma_request_reg <= 1'b0;
        else
            dma_request_reg <= ecp_en & dma_cfg & ecp_mode
                               & (dir_in | buf_in_ready);
    end

    // Buffer input: DMA strobes take priority over software writes.
    assign buf_in_valid = dma_push | sw_push;
    assign buf_in_data  = dma_push ? dma_wdata : w_data_reg[7:0];
    assign buf_in_ready = buf_count_reg != 2'h2;
    assign buf_out_valid = buf_count_reg != 2'h0;
    assign buf_pop      = buf_out_valid & port_data_ready;

    // Two-entry buffer storage and pointers.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            buf_wptr_reg  <= 1'b0;
            buf_rptr_reg  <= 1'b0;
            buf_count_reg <= 2'h0;
            buf_mem[0]    <= `PPEDP_RST_BYTE;
            buf_mem[1]    <= `PPEDP_RST_BYTE;
        end
        else
        begin
            if (buf_in_valid && buf_in_ready)
            begin
                buf_mem[buf_wptr_reg] <= buf_in_data;
                buf_wptr_reg          <= ~buf_wptr_reg;
            end
            if (buf_pop)
                buf_rptr_reg <= ~buf_rptr_reg;
            buf_count_reg <= buf_count_reg
                             + {1'b0, buf_in_valid & buf_in_ready}
                             - {1'b0, buf_pop};
        end
    end

    // Buffer output onto the data lines, driven only in forward direction.
    assign port_data_lines_o    = buf_mem[buf_rptr_reg];
    assign port_data_valid      = buf_out_valid & ~dir_in;
    assign port_data_lines_oe_n = dir_in;

    // AXI write: address and data are held until both are present.
    assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
    assign wr_is_data    = aw_addr_reg == `PPEDP_OFF_DATA;
    assign wr_go   = aw_held_reg & w_held_reg
                     & (~wr_is_data | (buf_in_ready & ~dma_push));
    assign sw_push = wr_go & wr_is_data & w_strb_reg[0];
    assign wr_bad  = !(aw_addr_reg == `PPEDP_OFF_PMC
                       || aw_addr_reg == `PPEDP_OFF_PCFG
                       || aw_addr_reg == `PPEDP_OFF_FCTL
                       || aw_addr_reg == `PPEDP_OFF_PCTL
                       || wr_is_data);

    // Capture of write address and data channels.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 6'h00;
            w_held_reg  <= 1'b0;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[5:2], 2'h0};
            end
            else if (wr_go)
                aw_held_reg <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            else if (wr_go)
                w_held_reg <= 1'b0;
        end
    end

    // Write response.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PPEDP_RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_bad ? `PPEDP_RESP_SLVERR : `PPEDP_RESP_OKAY;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Control register writes, low byte lane only.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            power_mode_control_reg <= `PPEDP_RST_BYTE;
            port_config_ctrl_reg   <= `PPEDP_RST_BYTE;
            function_control_reg   <= `PPEDP_RST_BYTE;
            port_ctrl_reg          <= `PPEDP_RST_BYTE;
        end
        else if (wr_go && w_strb_reg[0])
        begin
            case (aw_addr_reg)
                `PPEDP_OFF_PMC:  power_mode_control_reg <= w_data_reg[7:0];
                `PPEDP_OFF_PCFG: port_config_ctrl_reg   <= w_data_reg[7:0];
                `PPEDP_OFF_FCTL: function_control_reg   <= w_data_reg[7:0];
                `PPEDP_OFF_PCTL: port_ctrl_reg          <= w_data_reg[7:0];
                default: ;
            endcase
        end
    end

    // AXI read: one outstanding read, data registered with the response.
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `PPEDP_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `PPEDP_RESP_OKAY;
            case ({s_axi_araddr[5:2], 2'h0})
                `PPEDP_OFF_PMC:
                    s_axi_rdata <= {24'h000000, power_mode_control_reg};
                `PPEDP_OFF_PCFG:
                    s_axi_rdata <= {24'h000000, port_config_ctrl_reg};
                `PPEDP_OFF_FCTL:
                    s_axi_rdata <= {24'h000000, function_control_reg};
                `PPEDP_OFF_PCTL:
                    s_axi_rdata <= {24'h000000, port_ctrl_reg};
                `PPEDP_OFF_STAT:
                    s_axi_rdata <= {22'h000000, buf_count_reg,
                                    printer_dma_request, ack_active,
                                    ident_in, drive_two_present,
                                    shared_port_mode, ~printer_select_n_i,
                                    select_sync_reg[1],
                                    paper_sync_reg[1]};
                `PPEDP_OFF_DATA:
                    s_axi_rdata <= {24'h000000, port_data_lines_i};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `PPEDP_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule : ppedp_top
`default_nettype wire

// ### test/ppedp_props.sv
// Concurrent checks on the ports of the printer port pin logic.
`timescale 1ns/10ps
`default_nettype none
module ppedp_props
(
    // Clock and reset.
    input wire logic                   aclk,
    input wire logic                   aresetn,
    // Bus handshakes.
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready,
    input wire logic [31:0]            s_axi_rdata,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready,
    input wire logic [1:0]             s_axi_bresp,
    // Pins.
    input wire logic                   printer_dma_request,
    input wire logic                   printer_dma_request_oe_n,
    input wire logic                   ident_in,
    input wire logic                   printer_select_n_o,
    input wire logic                   printer_select_n_oe_n,
    input wire logic                   shared_port_mode,
    input wire logic                   drive_two_present,
    input wire logic                   printer_or_floppy_select,
    input wire logic                   port_data_valid,
    input wire logic                   port_data_ready,
    input wire ppedp_pkg::ppedp_byte_t port_data_lines_o
);
    import ppedp_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Steps of a register read.
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_rd_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    // The read answer comes on time; both answers stand until taken.
    a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_rd_hold: assert property (s_rd_wait
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    // Pin relations.
    a_req_driven: assert property (printer_dma_request
        |-> !printer_dma_request_oe_n) else $error("request on floating pin");
    a_ident_forced: assert property (!printer_dma_request_oe_n
        |-> ident_in) else $error("ident not one");
    a_select_low: assert property (!printer_select_n_oe_n
        |-> !printer_select_n_o) else $error("select not low");
    a_floppy_mode: assert property (!shared_port_mode
        |-> !printer_or_floppy_select && !drive_two_present)
        else $error("bad floppy mode");
    a_drive_two: assert property (drive_two_present
        |-> printer_or_floppy_select && shared_port_mode)
        else $error("bad drive two");
    a_reset_quiet: assert property ($rose(aresetn)
        |-> !printer_dma_request[*3]) else $error("request after reset");
    a_data_hold: assert property (port_data_valid
        && !port_data_ready |=> port_data_valid
        && $stable(port_data_lines_o)) else $error("data dropped");
endmodule : ppedp_props
bind ppedp_top ppedp_props u_props (.aclk, .aresetn, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .printer_dma_request,
    .printer_dma_request_oe_n, .ident_in, .printer_select_n_o,
    .printer_select_n_oe_n, .shared_port_mode, .drive_two_present,
    .printer_or_floppy_select, .port_data_valid, .port_data_ready,
    .port_data_lines_o);
`default_nettype wire

// ### test/ppedp_printer.sv
// Behavioural printer standing on the far side of the port pins.
`timescale 1ns/10ps
`default_nettype none
module ppedp_printer
(
    // Clock and scenario controls.
    input  wire logic       aclk,
    input  wire logic       no_paper,
    input  wire logic       online,
    input  wire logic       stall,
    input  wire logic [7:0] send_byte,
    // Port pins.
    input  wire logic       sel_oe_n,
    input  wire logic [7:0] data_o,
    input  wire logic       data_oe_n,
    input  wire logic       data_valid,
    output var  logic       data_ready,
    output var  logic [7:0] data_i,
    output var  logic       sel_wire,
    output var  logic       paper_out,
    output var  logic       printer_selected
);
    logic [7:0] got [$];
    // Status lines go high when out of paper and when online.
    assign paper_out = no_paper;
    assign printer_selected = online;
    // The select wire is pulled up unless the device drives it low.
    assign sel_wire = sel_oe_n ? 1'b1 : 1'b0;
    // The printer drives the data lines only when the device lets go.
    assign data_i = data_oe_n ? send_byte : data_o;
    assign data_ready = !stall;
    // Bytes taken from the port, oldest first.
    always @(posedge aclk)
        if (data_valid && data_ready) got.push_back(data_o);
endmodule : ppedp_printer
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the printer port pin logic.
`timescale 1ns/10ps
`default_nettype none
`include "ppedp_regs.svh"
module tb;
    import ppedp_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, printer_dma_ack_n, dma_rd_n;
    logic dma_wr_n, printer_select_n_i, printer_or_floppy_select;
    logic paper_out, printer_selected, port_data_ready, port_data_valid;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, printer_dma_request, printer_dma_request_oe_n;
    logic printer_select_n_o, printer_select_n_oe_n, shared_port_mode;
    logic drive_two_present, ident_in, port_data_lines_oe_n;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    ppedp_byte_t dma_wdata, dma_rdata, port_data_lines_i, port_data_lines_o;
    logic no_paper, online, stall;
    ppedp_byte_t send_byte;
    int err_total, n_compared;
    ppedp_top DUT (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .printer_dma_ack_n,
        .dma_rd_n, .dma_wr_n, .dma_wdata, .dma_rdata, .printer_dma_request,
        .printer_dma_request_oe_n, .paper_out, .printer_selected,
        .printer_select_n_i, .printer_select_n_o, .printer_select_n_oe_n,
        .printer_or_floppy_select, .shared_port_mode, .drive_two_present,
        .ident_in, .port_data_lines_i, .port_data_lines_o,
        .port_data_lines_oe_n, .port_data_valid, .port_data_ready);
    ppedp_printer P (.aclk, .no_paper, .online, .stall, .send_byte,
        .sel_oe_n(printer_select_n_oe_n), .data_o(port_data_lines_o),
        .data_oe_n(port_data_lines_oe_n), .data_valid(port_data_valid),
        .data_ready(port_data_ready), .data_i(port_data_lines_i),
        .sel_wire(printer_select_n_i), .paper_out, .printer_selected);
    // Clock at 40 MHz.
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    // Compares one value and reports a mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One clock edge with a bound on the wait.
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 200)
        begin
            err_total++;
            test_done();
        end
    endtask : tick
    // Register write; each channel is released when taken.
    // A nonzero hold keeps bready low until that many edges have passed.
    task automatic wr(input logic [5:0] a, input logic [7:0] d,
                      input logic [1:0] er = `PPEDP_RESP_OKAY,
                      input int hold = 0);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {2'h3, hold == 0};
        do
        begin
            tick(n);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (n == hold) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        chk(32'(s_axi_bresp), 32'(er));
    endtask : wr
    // Register read; a nonzero hold delays rready the same way.
    task automatic rd(input logic [5:0] a, output logic [31:0] d,
                      input logic [1:0] er = `PPEDP_RESP_OKAY,
                      input int hold = 0);
        int n;
        n = 0;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= {1'b1, hold == 0};
        do
        begin
            tick(n);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (n == hold) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        d = s_axi_rdata;
        chk(32'(s_axi_rresp), 32'(er));
    endtask : rd
    // One acknowledged DMA strobe: write when wr_op is set, else read.
    task automatic dstb(input logic wr_op, input logic [7:0] b);
        @(posedge aclk);
        printer_dma_ack_n <= 1'b0;
        dma_rd_n <= wr_op;
        dma_wr_n <= !wr_op;
        dma_wdata <= b;
        repeat (2) @(posedge aclk);
        {printer_dma_ack_n, dma_rd_n, dma_wr_n} <= 3'h7;
        @(posedge aclk);
    endtask : dstb
    // Main sequence.
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, no_paper, online, stall} = 5'h0;
        {printer_dma_ack_n, dma_rd_n, dma_wr_n} = 3'h7;
        printer_or_floppy_select = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_wstrb, dma_wdata, send_byte} = {4'h1, 16'h0};
        {err_total, n_compared} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(printer_dma_request_oe_n, 1);
        chk(printer_dma_request, 0);
        chk(printer_select_n_oe_n, 1);
        rd(`PPEDP_OFF_PMC, v);
        chk(v, 0);
        rd(6'h18, v, `PPEDP_RESP_SLVERR);
        wr(`PPEDP_OFF_STAT, 8'hff, `PPEDP_RESP_SLVERR);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            {online, no_paper} <= i[1:0];
            repeat (3) @(posedge aclk);
            rd(`PPEDP_OFF_STAT, v);
            chk(v[1:0], i[1:0]);
        end
        for (int i = 0; i < 2; i++)
        begin
            wr(`PPEDP_OFF_PCTL, {4'h0, ~i[0], 3'h0});
            repeat (2) @(posedge aclk);
            chk(printer_select_n_oe_n, i[0]);
            chk(printer_select_n_i, i[0]);
        end
        $display("test status and select done");
        for (int i = 0; i < 8; i++)
        begin
            wr(`PPEDP_OFF_FCTL, {5'h0, i[0], 2'h0});
            wr(`PPEDP_OFF_PMC, {4'h0, i[1], 3'h0});
            printer_or_floppy_select <= i[2];
            printer_dma_ack_n <= !i[2];
            repeat (2) @(posedge aclk);
            chk(shared_port_mode, i[0] ? i[2] : 1'b1);
            chk(drive_two_present, i[0] ? 1'b0 : i[2]);
            chk(ident_in, i[1] ? 1'b1 : !i[2]);
        end
        printer_dma_ack_n <= 1'b1;
        $display("test pin decode done");
        wr(`PPEDP_OFF_PCTL, 8'h60);
        wr(`PPEDP_OFF_PCFG, 8'h00);
        repeat (3) @(posedge aclk);
        chk(printer_dma_request_oe_n, 1);
        wr(`PPEDP_OFF_PCFG, 8'h04, `PPEDP_RESP_OKAY, 3);
        repeat (3) @(posedge aclk);
        chk({printer_dma_request_oe_n, printer_dma_request}, 1);
        stall <= 1'b1;
        dstb(1'b1, 8'h3c);
        dstb(1'b1, 8'hc3);
        chk(printer_dma_request, 0);
        chk({port_data_valid, port_data_lines_o}, 9'h13c);
        stall <= 1'b0;
        repeat (4) @(posedge aclk);
        chk(P.got.size(), 32'd2);
        chk({16'h0, P.got[0], P.got[1]}, 32'h3cc3);
        chk(printer_dma_request, 1);
        wr(`PPEDP_OFF_PCTL, 8'h00);
        dstb(1'b1, 8'h55);
        chk({port_data_valid, printer_dma_request}, 0);
        wr(`PPEDP_OFF_PCTL, 8'h60);
        wr(`PPEDP_OFF_PMC, 8'h00);
        dstb(1'b1, 8'h5a);
        chk({port_data_valid, printer_dma_request_oe_n}, 1);
        $display("test dma write done");
        wr(`PPEDP_OFF_PMC, 8'h08);
        wr(`PPEDP_OFF_PCTL, 8'h70);
        send_byte <= 8'ha5;
        dstb(1'b0, 8'h00);
        chk(dma_rdata, 8'ha5);
        chk(port_data_lines_oe_n, 1);
        rd(`PPEDP_OFF_DATA, v, `PPEDP_RESP_OKAY, 2);
        chk(v, 32'ha5);
        $display("test dma read done");
        test_done();
    end
endmodule : tb
`default_nettype wire
